// ==== hw/sdram_ctl_end.sv ====
// controller end: closed-page access sequencer with a two-entry write buffer
`timescale 1ns/100ps
`default_nettype none
module sdram_ctl_end #(
  parameter int COL_W = 4,
  parameter logic [2:0] BURST_SETTING = sdram_pkg::BURST_LENGTH_SETTING,
  parameter int READ_LATENCY = sdram_pkg::READ_LATENCY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sdram_link_if.ctl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [sdram_pkg::BANK_W-1:0] req_bank,
  input wire logic [sdram_pkg::ADDR_W-1:0] req_row,
  input wire logic [COL_W-1:0] req_col,
  input wire logic [sdram_pkg::CNT_W-1:0] req_len,
  input wire logic req_auto_pre,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [sdram_pkg::DATA_W-1:0] wr_data,
  input wire logic [sdram_pkg::MASK_W-1:0] wr_mask,
  output logic rd_valid,
  output logic [sdram_pkg::DATA_W-1:0] rd_data
);
  localparam int DW = sdram_pkg::DATA_W;
  localparam int MW = sdram_pkg::MASK_W;
  localparam int CW = sdram_pkg::CNT_W;
  localparam int RL = READ_LATENCY;
  localparam bit FULL_PAGE = (BURST_SETTING == sdram_pkg::BURST_FULL_PAGE);
  localparam logic [CW-1:0] BURST_WORDS = CW'(1 << BURST_SETTING);
  localparam logic [CW-1:0] RCD_WAIT = CW'(sdram_pkg::ACTIVE_TO_ACCESS_CYCLES - 1);
  localparam logic [CW-1:0] RP_WAIT = CW'(sdram_pkg::PRECHARGE_RECOVERY_CYCLES - 1);
  localparam int WR_CYC = sdram_pkg::WRITE_RECOVERY_CYCLES;
  localparam logic [CW-1:0] WR_WAIT = CW'((WR_CYC > 1) ? WR_CYC - 2 : 0);

  typedef enum logic [2:0] {ST_IDLE, ST_OPEN, ST_WRITE, ST_READ, ST_RECOVER, ST_CLOSE} ctl_state_e;

  ctl_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d, n_q, n_d, len_eff;
  logic wr_op_q, wr_op_d, trunc_q, trunc_d, ap_q, ap_d;
  logic [sdram_pkg::BANK_W-1:0] bank_q, bank_d;
  logic [COL_W-1:0] col_q, col_d;
  sdram_pkg::cmd_e cmd_q, cmd_d;
  logic [sdram_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [MW-1:0] mask_q, mask_d;
  logic [DW-1:0] dq_q, dq_d;
  logic oe_q, oe_d, acc_q, acc_d, rdy_q, rdy_d, close_now, pop, push;
  logic [RL-1:0] rp_q, rp_d;
  logic rv_q;
  logic [DW-1:0] rdat_q;
  logic [1:0] bv_q, bv_d;
  logic [DW-1:0] bd_q [2];
  logic [DW-1:0] bd_d [2];
  logic [MW-1:0] bm_q [2];
  logic [MW-1:0] bm_d [2];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    n_d = n_q;
    wr_op_d = wr_op_q;
    trunc_d = trunc_q;
    ap_d = ap_q;
    bank_d = bank_q;
    col_d = col_q;
    cmd_d = sdram_pkg::CMD_NOP;
    addr_d = addr_q;
    mask_d = '1;
    dq_d = dq_q;
    oe_d = 1'b0;
    acc_d = 1'b0;
    pop = 1'b0;
    close_now = 1'b0;
    len_eff = (req_len == '0) ? CW'(1) : req_len;
    if (!FULL_PAGE && len_eff > BURST_WORDS) begin
      len_eff = BURST_WORDS;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (req_valid && rdy_q) begin
          cmd_d = sdram_pkg::CMD_ACTIVE;
          bank_d = req_bank;
          addr_d = req_row;
          col_d = req_col;
          wr_op_d = req_write;
          n_d = len_eff - 1'b1;
          trunc_d = FULL_PAGE || len_eff < BURST_WORDS;
          // auto precharge only on whole fixed bursts
          ap_d = req_auto_pre && !(FULL_PAGE || len_eff < BURST_WORDS); // [R01] [R04] [R13]
          cnt_d = RCD_WAIT;
          st_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          cmd_d = wr_op_q ? sdram_pkg::CMD_WRITE : sdram_pkg::CMD_READ;
          addr_d = '0;
          addr_d[sdram_pkg::ALL_BANK_SELECT_BIT] = ap_q;
          addr_d[COL_W-1:0] = col_q;
          oe_d = wr_op_q; // [R07]
          acc_d = !wr_op_q;
          st_d = wr_op_q ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (n_q != '0) begin
          oe_d = 1'b1; // [R07] [R10]
          n_d = n_q - 1'b1;
        end else if (WR_CYC == 1) begin
          close_now = 1'b1;
        end else begin
          // data on the terminate edge is masked as well as ignored
          cmd_d = trunc_q ? sdram_pkg::CMD_BURST_TERM : sdram_pkg::CMD_NOP; // [R14] [R17]
          cnt_d = WR_WAIT;
          st_d = ST_RECOVER;
        end
      end
      ST_READ: begin
        if (n_q != '0) begin
          acc_d = 1'b1;
          n_d = n_q - 1'b1;
        end else if (trunc_q) begin
          cmd_d = sdram_pkg::CMD_BURST_TERM; // [R04] [R05]
          cnt_d = '0;
          st_d = ST_RECOVER;
        end else begin
          close_now = 1'b1; // [R02]
        end
      end
      ST_RECOVER: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          close_now = 1'b1; // [R13] [R14]
        end
      end
      ST_CLOSE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          st_d = ST_IDLE; // [R03] [R21]
        end
      end
    endcase
    if (close_now) begin
      cmd_d = ap_q ? sdram_pkg::CMD_NOP : sdram_pkg::CMD_PRECHARGE; // [R18]
      addr_d = '0; // [R19]
      cnt_d = RP_WAIT;
      st_d = ST_CLOSE;
    end
    // an empty buffer at a data slot sends a fully masked word
    if (oe_d) begin
      if (bv_q[0]) begin
        dq_d = bd_q[0];
        mask_d = bm_q[0]; // [R20]
        pop = 1'b1;
      end
    end
    rdy_d = (st_d == ST_IDLE);
    rp_d = {rp_q[RL-2:0], acc_q};
  end

  assign push = wr_valid & ~bv_q[1];

  always_comb begin
    bv_d = bv_q;
    bd_d = bd_q;
    bm_d = bm_q;
    if (pop) begin
      bv_d = {1'b0, bv_q[1]};
      bd_d[0] = bd_q[1];
      bm_d[0] = bm_q[1];
    end
    if (push) begin
      if (!bv_d[0]) begin
        bv_d[0] = 1'b1;
        bd_d[0] = wr_data;
        bm_d[0] = wr_mask;
      end else begin
        bv_d[1] = 1'b1;
        bd_d[1] = wr_data;
        bm_d[1] = wr_mask;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      n_q <= '0;
      wr_op_q <= 1'b0;
      trunc_q <= 1'b0;
      ap_q <= 1'b0;
      bank_q <= '0;
      col_q <= '0;
      cmd_q <= sdram_pkg::CMD_NOP;
      addr_q <= '0;
      mask_q <= '1;
      dq_q <= '0;
      oe_q <= 1'b0;
      acc_q <= 1'b0;
      rdy_q <= 1'b0;
      rp_q <= '0;
      rv_q <= 1'b0;
      rdat_q <= '0;
      bv_q <= '0;
      bd_q[0] <= '0;
      bd_q[1] <= '0;
      bm_q[0] <= '0;
      bm_q[1] <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      n_q <= n_d;
      wr_op_q <= wr_op_d;
      trunc_q <= trunc_d;
      ap_q <= ap_d;
      bank_q <= bank_d;
      col_q <= col_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      acc_q <= acc_d;
      rdy_q <= rdy_d;
      rp_q <= rp_d;
      rv_q <= rp_q[RL-1];
      rdat_q <= link.dq;
      bv_q <= bv_d;
      bd_q <= bd_d;
      bm_q <= bm_d;
    end
  end

  assign link.cmd = cmd_q;
  assign link.bank = bank_q;
  assign link.addr = addr_q;
  assign link.mask = mask_q;
  assign link.dq_ctl_out = dq_q;
  assign link.dq_ctl_oe = oe_q;
  assign req_ready = rdy_q;
  assign wr_ready = ~bv_q[1];
  assign rd_valid = rv_q;
  assign rd_data = rdat_q;
endmodule
`default_nettype wire

// ==== hw/sdram_link_if.sv ====
// command, address, mask and shared data wires between controller and memory
`timescale 1ns/100ps
`default_nettype none
interface sdram_link_if (
  input wire logic clk_sys
);
  sdram_pkg::cmd_e cmd;
  logic [sdram_pkg::BANK_W-1:0] bank;
  logic [sdram_pkg::ADDR_W-1:0] addr;
  logic [sdram_pkg::MASK_W-1:0] mask;
  logic [sdram_pkg::DATA_W-1:0] dq_ctl_out;
  logic dq_ctl_oe;
  logic [sdram_pkg::DATA_W-1:0] dq_mem_out;
  logic dq_mem_oe;
  logic [sdram_pkg::DATA_W-1:0] dq;
  // an undriven bus reads as zero
  assign dq = dq_ctl_oe ? dq_ctl_out : (dq_mem_oe ? dq_mem_out : '0);
  modport ctl (input clk_sys, output cmd, bank, addr, mask, dq_ctl_out, dq_ctl_oe, input dq);
  modport mem (input clk_sys, cmd, bank, addr, mask, dq, output dq_mem_out, dq_mem_oe);
endinterface
`default_nettype wire

// ==== hw/sdram_mem_end.sv ====
// memory end: bank state, burst sequencing, read pipeline and storage array
//
// Contract
// R01: precharge cuts read burst unless auto precharge
// R02: read precharge issued latency-minus-one before last
// R03: no same-bank command before precharge recovery
// R04: burst terminate cuts read unless auto precharge
// R05: read terminate issued latency-minus-one before last
// R06: write carries column, bank, auto precharge choice
// R07: first write word on command edge
// R08: finished write burst ignores data, pins undriven
// R09: full page write wraps to column zero
// R10: new write cuts old; data goes new
// R11: writes accepted every cycle, any bank
// R12: read stops write burst from its edge
// R13: write precharge one write recovery after last
// R14: mask before and at truncating precharge
// R15: internal precharge delayed by write recovery
// R16: auto precharge write-back takes recovery clocks
// R17: terminate edge data ignored, prior word kept
// R18: optimum precharge equals auto precharge result
// R19: all bank bit selects all banks
// R20: byte mask applies same edge, zero latency
// R21: recovery times round up to cycles
`timescale 1ns/100ps
`default_nettype none
module sdram_mem_end #(
  parameter int ROW_W = 2,
  parameter int COL_W = 4,
  parameter logic [2:0] BURST_SETTING = sdram_pkg::BURST_LENGTH_SETTING,
  parameter int READ_LATENCY = sdram_pkg::READ_LATENCY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sdram_link_if.mem link,
  output logic proto_err,
  output logic [sdram_pkg::NUM_BANKS-1:0] bank_open
);
  localparam int NB = sdram_pkg::NUM_BANKS;
  localparam int DW = sdram_pkg::DATA_W;
  localparam int MW = sdram_pkg::MASK_W;
  localparam int BW = sdram_pkg::BANK_W;
  localparam int CW = sdram_pkg::CNT_W;
  localparam int RL = READ_LATENCY;
  localparam int AB = sdram_pkg::ALL_BANK_SELECT_BIT;
  localparam int AW = BW + ROW_W + COL_W;
  localparam bit FULL_PAGE = (BURST_SETTING == sdram_pkg::BURST_FULL_PAGE);
  localparam logic [CW-1:0] BURST_WORDS = CW'(1 << BURST_SETTING);
  localparam logic [CW-1:0] RP_WAIT = CW'(sdram_pkg::PRECHARGE_RECOVERY_CYCLES - 1);
  localparam logic [CW-1:0] WR_CYC = CW'(sdram_pkg::WRITE_RECOVERY_CYCLES);
  localparam logic [CW-1:0] WR_EXT = CW'(sdram_pkg::WRITE_RECOVERY_CYCLES - 1);

  logic [DW-1:0] mem_q [2**AW];

  logic [NB-1:0] open_q, open_d;
  logic [NB-1:0] apw_on_q, apw_on_d;
  logic [ROW_W-1:0] row_q [NB];
  logic [ROW_W-1:0] row_d [NB];
  logic [CW-1:0] rcv_q [NB];
  logic [CW-1:0] rcv_d [NB];
  logic [CW-1:0] apw_q [NB];
  logic [CW-1:0] apw_d [NB];

  logic act_q, act_d;
  logic wr_q, wr_d;
  logic ap_q, ap_d;
  logic wrote_q, wrote_d;
  logic err_q, err_d;
  logic [BW-1:0] bb_q, bb_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [CW-1:0] left_q, left_d;

  logic [RL-1:0] pv_q, pv_d;
  logic [DW-1:0] pd_q [RL];
  logic [DW-1:0] pd_d [RL];

  logic is_rd, is_wr, is_pre, is_bt, all_bit, stop_old;
  logic acc, acc_wr;
  logic [BW-1:0] acc_bank;
  logic [COL_W-1:0] acc_col;
  logic [AW-1:0] acc_addr;

  assign is_rd = (link.cmd == sdram_pkg::CMD_READ);
  assign is_wr = (link.cmd == sdram_pkg::CMD_WRITE);
  assign is_pre = (link.cmd == sdram_pkg::CMD_PRECHARGE);
  assign is_bt = (link.cmd == sdram_pkg::CMD_BURST_TERM);
  assign all_bit = link.addr[AB];

  always_comb begin
    open_d = open_q;
    apw_on_d = apw_on_q;
    row_d = row_q;
    apw_d = apw_q;
    act_d = act_q;
    wr_d = wr_q;
    ap_d = ap_q;
    bb_d = bb_q;
    col_d = col_q;
    left_d = left_q;
    err_d = 1'b0;
    wrote_d = act_q & wr_q;
    acc = 1'b0;
    acc_wr = 1'b0;
    acc_bank = bb_q;
    acc_col = col_q;
    for (int b = 0; b < NB; b++) begin
      rcv_d[b] = (rcv_q[b] != '0) ? rcv_q[b] - 1'b1 : rcv_q[b];
      // pending auto precharge closes the row once its wait runs out
      if (apw_on_q[b]) begin
        if (apw_q[b] <= CW'(1)) begin
          apw_on_d[b] = 1'b0;
          open_d[b] = 1'b0; // [R06] [R18]
          rcv_d[b] = RP_WAIT;
        end else begin
          apw_d[b] = apw_q[b] - 1'b1;
        end
      end
    end

    // a precharge only stops the burst when it reaches the burst's bank
    stop_old = is_rd | is_wr | is_bt | (is_pre & (all_bit | (link.bank == bb_q)));
    if (act_q) begin
      if (stop_old) begin
        act_d = 1'b0; // [R10] [R12] [R17]
        if ((is_bt | is_pre) & ap_q) begin
          err_d = 1'b1; // [R01] [R04] [R13]
        end
        if ((is_rd | is_wr) & ap_q) begin
          // interrupted auto precharge burst still closes its own bank
          apw_on_d[bb_q] = 1'b1;
          apw_d[bb_q] = wr_q ? WR_CYC : CW'(1); // [R16]
        end
      end else begin
        acc = 1'b1; // [R07]
        acc_wr = wr_q;
        col_d = col_q + 1'b1; // [R09]
        left_d = left_q - 1'b1;
        if (!FULL_PAGE && left_q == CW'(1)) begin
          act_d = 1'b0; // [R08]
          if (ap_q) begin
            apw_on_d[bb_q] = 1'b1;
            apw_d[bb_q] = wr_q ? WR_CYC : CW'(1); // [R16]
          end
        end
      end
    end

    unique case (link.cmd)
      sdram_pkg::CMD_NOP, sdram_pkg::CMD_BURST_TERM: begin
      end
      sdram_pkg::CMD_ACTIVE: begin
        if (open_q[link.bank] || rcv_q[link.bank] != '0) begin
          err_d = 1'b1; // [R03]
        end else begin
          open_d[link.bank] = 1'b1;
          row_d[link.bank] = link.addr[ROW_W-1:0];
        end
      end
      sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
        if (!open_q[link.bank] || rcv_q[link.bank] != '0 || apw_on_q[link.bank]) begin
          err_d = 1'b1; // [R03]
        end else begin
          acc = 1'b1; // [R07] [R11]
          acc_wr = is_wr;
          acc_bank = link.bank;
          acc_col = link.addr[COL_W-1:0];
          bb_d = link.bank;
          col_d = link.addr[COL_W-1:0] + 1'b1;
          wr_d = is_wr;
          ap_d = all_bit; // [R06]
          left_d = BURST_WORDS - 1'b1;
          act_d = FULL_PAGE || BURST_WORDS != CW'(1);
          if (!act_d && all_bit) begin
            apw_on_d[link.bank] = 1'b1;
            apw_d[link.bank] = is_wr ? WR_CYC : CW'(1); // [R16]
          end
        end
      end
      sdram_pkg::CMD_PRECHARGE: begin
        for (int b = 0; b < NB; b++) begin
          if (all_bit || link.bank == BW'(b)) begin // [R19]
            if (rcv_q[b] != '0) begin
              err_d = 1'b1; // [R03]
            end
            open_d[b] = 1'b0;
            apw_on_d[b] = 1'b0;
            // right after write data the array is busy for write recovery
            rcv_d[b] = (wrote_q && bb_q == BW'(b)) ? RP_WAIT + WR_EXT : RP_WAIT; // [R15]
          end
        end
      end
      default: begin
        err_d = 1'b1;
      end
    endcase

    acc_addr = {acc_bank, row_q[acc_bank], acc_col};
    pv_d[0] = acc & ~acc_wr; // [R02] [R05]
    pd_d[0] = mem_q[acc_addr];
    for (int i = 1; i < RL; i++) begin
      pv_d[i] = pv_q[i-1];
      pd_d[i] = pd_q[i-1];
    end
  end

  // storage has no reset; the bank, burst, error and read pipeline state get one
  always_ff @(posedge clk_sys) begin
    if (acc && acc_wr) begin
      for (int m = 0; m < MW; m++) begin
        if (!link.mask[m]) begin
          mem_q[acc_addr][m*8 +: 8] <= link.dq[m*8 +: 8]; // [R20]
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      open_q <= '0;
      apw_on_q <= '0;
      for (int b = 0; b < NB; b++) begin
        row_q[b] <= '0;
        rcv_q[b] <= '0;
        apw_q[b] <= '0;
      end
      act_q <= 1'b0;
      wr_q <= 1'b0;
      ap_q <= 1'b0;
      wrote_q <= 1'b0;
      err_q <= 1'b0;
      bb_q <= '0;
      col_q <= '0;
      left_q <= '0;
      pv_q <= '0;
      for (int i = 0; i < RL; i++) begin
        pd_q[i] <= '0;
      end
    end else begin
      open_q <= open_d;
      apw_on_q <= apw_on_d;
      row_q <= row_d;
      rcv_q <= rcv_d;
      apw_q <= apw_d;
      act_q <= act_d;
      wr_q <= wr_d;
      ap_q <= ap_d;
      wrote_q <= wrote_d;
      err_q <= err_d;
      bb_q <= bb_d;
      col_q <= col_d;
      left_q <= left_d;
      pv_q <= pv_d;
      pd_q <= pd_d;
    end
  end

  // pins are driven only by read words leaving the pipeline
  assign link.dq_mem_out = pd_q[RL-1];
  assign link.dq_mem_oe = pv_q[RL-1]; // [R08]
  assign proto_err = err_q;
  assign bank_open = open_q;
endmodule
`default_nettype wire

// ==== hw/sdram_pkg.sv ====
// shared constants and command codes for the sdram command link
package sdram_pkg;
  localparam int DATA_W = 16;
  localparam int MASK_W = DATA_W / 8;
  localparam int ADDR_W = 11;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ALL_BANK_SELECT_BIT = 10;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PRECHARGE_RECOVERY_TIME_NS = 20;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int ACTIVE_TO_ACCESS_TIME_NS = 20;
  // least times round up to whole cycles
  localparam int PRECHARGE_RECOVERY_CYCLES =
    (PRECHARGE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_RECOVERY_CYCLES =
    (WRITE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACTIVE_TO_ACCESS_CYCLES =
    (ACTIVE_TO_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_LATENCY_CYCLES = 2;
  // burst_length_setting: 0..3 give 1,2,4,8 words, 7 is full page
  localparam logic [2:0] BURST_LENGTH_SETTING = 3'h2;
  localparam logic [2:0] BURST_FULL_PAGE = 3'h7;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_BURST_TERM
  } cmd_e;
endpackage

// ==== tb/sdram_burst_truncation_write_assertions.sv ====
// concurrent checks on the link between the controller end and the memory end
`timescale 1ns/100ps
`default_nettype none
module sdram_burst_truncation_write_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input var sdram_pkg::cmd_e cmd,
  input wire logic [sdram_pkg::ADDR_W-1:0] addr,
  input wire logic [sdram_pkg::MASK_W-1:0] mask,
  input wire logic dq_ctl_oe,
  input wire logic dq_mem_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // the terminate cycle is itself the write recovery gap, so the close follows at once
  sequence s_close;
    cmd == sdram_pkg::CMD_BURST_TERM ##1 cmd == sdram_pkg::CMD_PRECHARGE;
  endsequence
  sequence s_access;
    cmd == sdram_pkg::CMD_NOP ##1 cmd inside {sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE};
  endsequence
  a_write_first_word:
    assert property (cmd == sdram_pkg::CMD_WRITE |-> dq_ctl_oe && !dq_mem_oe)
    else $error("write command without its first word");
  a_word_starts_write:
    assert property ($rose(dq_ctl_oe) |-> cmd == sdram_pkg::CMD_WRITE)
    else $error("write data started without a write command");
  a_term_drops_word:
    assert property ($past(dq_ctl_oe) && cmd == sdram_pkg::CMD_BURST_TERM |-> !dq_ctl_oe && mask == 2'h3)
    else $error("word driven unmasked on the terminate edge");
  a_term_then_close:
    assert property ($past(dq_ctl_oe) && cmd == sdram_pkg::CMD_BURST_TERM |-> s_close)
    else $error("cut write not closed after recovery");
  a_write_recovery:
    assert property ($fell(dq_ctl_oe) |-> cmd != sdram_pkg::CMD_PRECHARGE)
    else $error("precharge inside write recovery");
  a_precharge_gap:
    assert property (cmd == sdram_pkg::CMD_PRECHARGE |=> cmd == sdram_pkg::CMD_NOP [*2])
    else $error("command inside precharge recovery");
  a_active_to_access:
    assert property (cmd == sdram_pkg::CMD_ACTIVE |=> s_access)
    else $error("access not two cycles after activate");
  a_read_word_out:
    assert property (cmd == sdram_pkg::CMD_READ |-> ##[1:2] dq_mem_oe)
    else $error("read word not driven at latency");
  a_read_closes:
    assert property (cmd == sdram_pkg::CMD_READ && !addr[sdram_pkg::ALL_BANK_SELECT_BIT]
      |-> ##[1:4] cmd inside {sdram_pkg::CMD_PRECHARGE, sdram_pkg::CMD_BURST_TERM})
    else $error("read burst left open");
  a_burst_bounded:
    assert property ($rose(dq_ctl_oe) |-> ##[1:4] !dq_ctl_oe)
    else $error("write data runs past the burst");
  a_no_contention:
    assert property (dq_mem_oe |-> !dq_ctl_oe && cmd != sdram_pkg::CMD_WRITE)
    else $error("both ends drive the data bus");
endmodule
`default_nettype wire

// ==== tb/sdram_burst_truncation_write_test.sv ====
// self-checking bench: both ends joined, plus a memory end driven by hand
`timescale 1ns/100ps
`default_nettype none
module sdram_burst_truncation_write_test;
  logic clk_sys, sys_rst, req_valid, req_ready, req_write, req_auto_pre;
  logic [sdram_pkg::BANK_W-1:0] req_bank;
  logic [sdram_pkg::ADDR_W-1:0] req_row;
  logic [3:0] req_col;
  logic [sdram_pkg::CNT_W-1:0] req_len;
  logic wr_valid, wr_ready, rd_valid, mem_err, err_b;
  logic err_b_seen = 1'b0;
  logic [sdram_pkg::DATA_W-1:0] wr_data, rd_data;
  logic [sdram_pkg::MASK_W-1:0] wr_mask;
  logic [sdram_pkg::NUM_BANKS-1:0] mem_open, open_b;
  logic [15:0] model [bit [7:0]];
  logic [15:0] rd_q [$];
  int num_errors = 0;
  int tests_run = 0;

  sdram_link_if link (.clk_sys(clk_sys));
  sdram_link_if link_b (.clk_sys(clk_sys));
  sdram_ctl_end u_sdram_ctl_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_len(req_len), .req_auto_pre(req_auto_pre), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_mask(wr_mask), .rd_valid(rd_valid), .rd_data(rd_data));
  sdram_mem_end u_sdram_mem_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .proto_err(mem_err),
    .bank_open(mem_open));
  // second memory end faces the bench so the far side can break the rules on purpose
  sdram_mem_end u_sdram_mem_end_b (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_b), .proto_err(err_b),
    .bank_open(open_b));
  sdram_burst_truncation_write_assertions u_checker (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(link.cmd),
    .addr(link.addr), .mask(link.mask), .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic done(input int t);
    $display("test %0d finished, %0d mismatches so far", t, num_errors);
  endtask

  // called at a rising edge; returns at the edge that took the word
  task automatic push(input logic [15:0] d, input logic [1:0] m);
    int i;
    wr_valid <= 1'b1;
    wr_data <= d;
    wr_mask <= m;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wr_ready !== 1'b1 && i < 50);
    check({15'h0000, wr_ready}, 16'h0001);
  endtask

  task automatic access(input logic wr, input logic [1:0] b, input logic [1:0] r, input logic [3:0] c,
      input logic [7:0] n, input logic ap);
    int i;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= b;
    req_row <= {9'h000, r};
    req_col <= c;
    req_len <= n;
    req_auto_pre <= ap;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (req_ready !== 1'b1 && i < 100);
    check({15'h0000, req_ready}, 16'h0001);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (req_ready !== 1'b1 && i < 200);
    check({15'h0000, req_ready}, 16'h0001);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // both words are buffered before the request, so neither of the first two data slots goes out empty
  task automatic wr_pair(input logic [1:0] b, input logic [1:0] r, input logic [3:0] c, input logic [15:0] d0,
      input logic [15:0] d1, input logic [1:0] m1, input logic ap);
    logic [15:0] old;
    @(posedge clk_sys);
    push(d0, 2'b00);
    push(d1, m1);
    wr_valid <= 1'b0;
    #1;
    check({15'h0000, wr_ready}, 16'h0000);
    old = (m1 != 2'b00) ? model[{b, r, c + 4'h1}] : 16'h0000;
    model[{b, r, c}] = d0;
    model[{b, r, c + 4'h1}] = {m1[1] ? old[15:8] : d1[15:8], m1[0] ? old[7:0] : d1[7:0]};
    // auto precharge only survives on a whole burst; the two empty slots go out masked
    access(1'b1, b, r, c, ap ? 8'h04 : 8'h02, ap);
    check({12'h000, mem_open}, 16'h0000);
  endtask

  task automatic rd_chk(input logic [1:0] b, input logic [1:0] r, input logic [3:0] c, input int n);
    rd_q.delete();
    access(1'b0, b, r, c, 8'(n), 1'b0);
    check(16'(rd_q.size()), 16'(n));
    for (int k = 0; k < n && k < rd_q.size(); k++) begin
      check(rd_q[k], model[{b, r, c + 4'(k)}]);
    end
  endtask

  task automatic drv_b(input sdram_pkg::cmd_e c, input logic [1:0] b, input logic [10:0] a);
    @(posedge clk_sys);
    link_b.cmd <= c;
    link_b.bank <= b;
    link_b.addr <= a;
  endtask

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      rd_q.push_back(rd_data);
    end
    if (sys_rst === 1'b0 && mem_err !== 1'b0) begin
      check({15'h0000, mem_err}, 16'h0000);
    end
    if (err_b === 1'b1) begin
      err_b_seen <= 1'b1;
    end
  end

  initial begin
    sys_rst = 1'b1;
    {req_valid, req_write, req_auto_pre, wr_valid} = 4'h0;
    {req_bank, req_row, req_col, req_len} = '0;
    {wr_data, wr_mask} = '0;
    link_b.cmd = sdram_pkg::CMD_NOP;
    {link_b.bank, link_b.addr, link_b.dq_ctl_out, link_b.dq_ctl_oe} = '0;
    link_b.mask = 2'h3;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int b = 0; b < 4; b++) begin
      wr_pair(2'(b), 2'h1, 4'h0, 16'hA000 + 16'(b), 16'hB000 + 16'(b), 2'b00, 1'b0);
      rd_chk(2'(b), 2'h1, 4'h0, 2);
    end
    wr_pair(2'h0, 2'h3, 4'hF, 16'hC0DE, 16'hD00D, 2'b00, 1'b0);
    rd_chk(2'h0, 2'h3, 4'hF, 2);
    done(1);
    wr_pair(2'h1, 2'h1, 4'h0, 16'h1234, 16'h5678, 2'b01, 1'b0);
    rd_chk(2'h1, 2'h1, 4'h0, 2);
    done(2);
    wr_pair(2'h2, 2'h2, 4'h4, 16'h0F0F, 16'hF0F0, 2'b00, 1'b1);
    rd_chk(2'h2, 2'h2, 4'h4, 2);
    done(3);
    wr_pair(2'h3, 2'h2, 4'h0, 16'h1111, 16'h2222, 2'b00, 1'b0);
    wr_pair(2'h3, 2'h2, 4'h2, 16'h3333, 16'h4444, 2'b00, 1'b0);
    rd_chk(2'h3, 2'h2, 4'h0, 4);
    rd_chk(2'h3, 2'h2, 4'h1, 1);
    done(4);
    drv_b(sdram_pkg::CMD_ACTIVE, 2'h0, 11'h001);
    drv_b(sdram_pkg::CMD_ACTIVE, 2'h1, 11'h002);
    repeat (3) drv_b(sdram_pkg::CMD_NOP, 2'h0, 11'h000);
    #1;
    check({12'h000, open_b}, 16'h0003);
    drv_b(sdram_pkg::CMD_PRECHARGE, 2'h3, 11'h400);
    repeat (2) drv_b(sdram_pkg::CMD_NOP, 2'h0, 11'h000);
    #1;
    check({12'h000, open_b}, 16'h0000);
    drv_b(sdram_pkg::CMD_ACTIVE, 2'h0, 11'h001);
    repeat (2) drv_b(sdram_pkg::CMD_NOP, 2'h0, 11'h000);
    drv_b(sdram_pkg::CMD_PRECHARGE, 2'h0, 11'h000);
    #1;
    check({15'h0000, err_b_seen}, 16'h0000);
    // activate one cycle after the close, well inside recovery
    drv_b(sdram_pkg::CMD_ACTIVE, 2'h0, 11'h001);
    repeat (4) drv_b(sdram_pkg::CMD_NOP, 2'h0, 11'h000);
    #1;
    check({15'h0000, err_b_seen}, 16'h0001);
    done(5);
    stop_test();
  end

  initial begin
    // about twenty accesses of under forty cycles each, with wide margin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
